// *** verilog/lcd_pkg.sv ***
// shared constants and types for the lcd command link
`default_nettype none
package lcd_pkg;
	typedef logic [7:0] lcd_byte_t;
	// ----------------------------------------------------------------
	// control byte and link
	// ----------------------------------------------------------------
	localparam int        RS_LSB     = 5;
	localparam logic [1:0] RS_CMD    = 2'h0;
	localparam logic [1:0] RS_DATA   = 2'h1;
	localparam lcd_byte_t CTRL_CMD   = 8'h00;
	localparam lcd_byte_t CTRL_DATA  = 8'h20;
	localparam int        FIFO_DEPTH = 16;
	// ----------------------------------------------------------------
	// command encodings
	// ----------------------------------------------------------------
	localparam lcd_byte_t INIT_BYTE0 = 8'h01;
	localparam lcd_byte_t INIT_BYTE1 = 8'h03;
	localparam logic [1:0] OP_PTR    = 2'h2;
	localparam logic [2:0] OP_FRAME  = 3'h1;
	localparam logic [5:0] OP_BIAS   = 6'h01;
	localparam logic [3:0] OP_MODE   = 4'h4;
	localparam logic [4:0] OP_OSC    = 5'h0A;
	// mode byte field positions
	localparam int        MODE_BPS   = 3;
	localparam int        MODE_INV   = 2;
	localparam int        MODE_PD    = 1;
	localparam int        MODE_E     = 0;
	// oscillator byte field positions
	localparam int        OSC_EFR    = 2;
	localparam int        OSC_COE    = 1;
	localparam int        OSC_SRC    = 0;
	// ----------------------------------------------------------------
	// reset values and limits
	// ----------------------------------------------------------------
	localparam logic [4:0] FD_RESET   = 5'h0E;
	localparam logic [4:0] FD_LAST    = 5'h16;
	localparam logic [1:0] BIAS_RESET = 2'h0;
	localparam logic [5:0] DP_RESET   = 6'h00;
	localparam logic [5:0] DP_MAX     = 6'h2B;
	localparam int        RAM_WORDS   = 44;
	localparam logic [5:0] FRAME_DIV  = 6'h30;

	// divide factor q of each prescaler code, zero when unused
	function automatic logic [6:0] lcd_q(input logic [4:0] fd);
		logic [6:0] q;
		q = 7'h00;
		unique case (fd)
			5'h00: q = 7'h50;
			5'h01: q = 7'h44;
			5'h02: q = 7'h3C;
			5'h03: q = 7'h35;
			5'h04: q = 7'h30;
			5'h05: q = 7'h2C;
			5'h06: q = 7'h28;
			5'h07: q = 7'h25;
			5'h08: q = 7'h22;
			5'h09: q = 7'h20;
			5'h0A: q = 7'h1E;
			5'h0B: q = 7'h1C;
			5'h0C: q = 7'h1B;
			5'h0D: q = 7'h19;
			5'h0E: q = 7'h18;
			5'h0F: q = 7'h17;
			5'h10: q = 7'h16;
			5'h11: q = 7'h15;
			5'h12: q = 7'h14;
			5'h13: q = 7'h13;
			5'h14: q = 7'h12;
			5'h15: q = 7'h11;
			5'h16: q = 7'h10;
			default: q = 7'h00;
		endcase
		return q;
	endfunction : lcd_q
endpackage : lcd_pkg
`default_nettype wire

// *** verilog/lcd_link_if.sv ***
// byte link between host and lcd driver
`timescale 1ns/100ps
`default_nettype none
interface lcd_link_if;
	import lcd_pkg::*;
	logic      valid;
	logic      ready;
	logic      ctrl;
	lcd_byte_t data;
	modport dev  (input valid, ctrl, data, output ready);
	modport host (output valid, ctrl, data, input ready);
endinterface : lcd_link_if
`default_nettype wire

// *** verilog/lcd_fifo.sv ***
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module lcd_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	wire              push = i_in_valid && o_in_ready;
	wire              pop  = o_out_valid && i_out_ready;

	assign o_in_ready  = (count != (AW+1)'(DEPTH));
	assign o_out_valid = (count != '0);
	assign o_out_data  = mem[rd_ptr];

	always_ff @(posedge i_ref_clk) begin
		if (push)
			mem[wr_ptr] <= i_in_data;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : lcd_fifo
`default_nettype wire

// *** verilog/lcd_dev.sv ***
// lcd driver end: command interpreter, pointer, display ram, prescaler
`timescale 1ns/100ps
`default_nettype none
// How it works
// R1 - five-bit code maps to divide factor q
// R2 - default code 01110 gives q 24
// R3 - frame equals clock over 48 times q
// R4 - top bits 10 load data pointer
// R5 - valid pointer values zero to 43
// R6 - bad pointer ignored, data dropped till valid
// R7 - pointer increments after each ram write
// R8 - data byte stored at current pointer
// R9 - data only after control select 01
// R10 - host sends initialize after power-on
// R11 - after init display off, outputs grounded
// R12 - init clears pointer, ram left alone
// R13 - oscillator internal, clock pin released
// R14 - reset gives documented field start values
// R15 - reset pin keeps ram contents
// R16 - host reinitializes after reset release
// R17 - host fills ram before display on; lcd_host does not enforce this and only flags a data write on o_ram_filled
// R18 - host follows start-up order
// R19 - commands dropped until initialize received
module lcd_dev (
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst_n,
	lcd_link_if.dev                link,
	input  wire logic [5:0]        i_rd_addr,
	output logic      [7:0]        o_rd_data,
	output logic                   o_initialized,
	output logic                   o_display_enable,
	output logic                   o_outputs_grounded,
	output logic                   o_backplane_select,
	output logic                   o_inversion_mode,
	output logic                   o_power_down,
	output logic      [1:0]        o_bias_select,
	output logic      [4:0]        o_frame_divider_code,
	output logic                   o_external_freq_range,
	output logic                   o_clock_output_enable,
	output logic                   o_oscillator_source,
	output logic      [5:0]        o_data_pointer,
	output logic                   o_pointer_valid,
	output logic                   o_frame_tick,
	input  wire logic              i_clock_pin,
	output logic                   o_clock_pin,
	output logic                   o_clock_pin_oe
);
	import lcd_pkg::*;

	typedef enum logic [0:0] {
		ST_TAKE = 1'b0,
		ST_EXEC = 1'b1
	} lcd_state_t;

	// ----------------------------------------------------------------
	// input fifo
	// ----------------------------------------------------------------
	logic       f_valid;
	logic [8:0] f_data;
	lcd_state_t state;
	wire        take = f_valid && (state == ST_TAKE);

	lcd_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) lcd_fifo_i (
		.i_ref_clk  (i_ref_clk),
		.i_rst_n    (i_rst_n),
		.i_in_valid (link.valid),
		.o_in_ready (link.ready),
		.i_in_data  ({link.ctrl, link.data}),
		.o_out_valid(f_valid),
		.i_out_ready(take),
		.o_out_data (f_data)
	);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	lcd_byte_t  cur;
	logic       cur_ctrl;
	logic [1:0] reg_sel;
	logic       init_half;
	logic [7:0] ram [RAM_WORDS];

	wire       is_init0 = (cur == INIT_BYTE0);
	wire       is_init1 = init_half && (cur == INIT_BYTE1);
	wire       exec     = (state == ST_EXEC) && !cur_ctrl;
	wire       cmd      = exec && (reg_sel == RS_CMD);
	wire       go       = cmd && o_initialized;          // R19
	wire       c_ptr    = go && (cur[7:6] == OP_PTR);     // R4
	wire       c_frame  = go && (cur[7:5] == OP_FRAME);
	wire       c_bias   = go && (cur[7:2] == OP_BIAS);
	wire       c_mode   = go && (cur[7:4] == OP_MODE);
	wire       c_osc    = go && (cur[7:3] == OP_OSC);
	wire       ptr_in   = (cur[5:0] <= DP_MAX);           // R5
	wire       fd_in    = (cur[4:0] <= FD_LAST);          // R1
	// R9 R6
	wire       wr_ram   = exec && (reg_sel == RS_DATA) && o_initialized
	                      && o_pointer_valid;
	wire       init_ok  = cmd && is_init1;
	wire [5:0] ptr_inc  = o_data_pointer + 6'h01;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			state <= ST_TAKE;
		end else begin
			unique case (state)
				ST_TAKE: state <= f_valid ? ST_EXEC : ST_TAKE;
				ST_EXEC: state <= ST_TAKE;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			cur      <= 8'h00;
			cur_ctrl <= 1'b0;
		end else if (take) begin
			cur      <= f_data[7:0];
			cur_ctrl <= f_data[8];
		end
	end

	// control byte selects what following bytes are
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			reg_sel <= RS_CMD;
		else if (state == ST_EXEC && cur_ctrl)
			reg_sel <= cur[RS_LSB+1:RS_LSB];                 // R9
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			init_half     <= 1'b0;
			o_initialized <= 1'b0;                           // R19
		end else if (cmd) begin
			init_half <= is_init0;
			if (is_init1)
				o_initialized <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// command fields
	// ----------------------------------------------------------------
	// reset and initialize both restore the starting fields
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n || init_ok) begin
			o_backplane_select    <= 1'b0;                   // R14
			o_inversion_mode      <= 1'b0;
			o_power_down          <= 1'b0;
			o_display_enable      <= 1'b0;                   // R11
			o_external_freq_range <= 1'b0;
			o_clock_output_enable <= 1'b0;                   // R13
			o_oscillator_source   <= 1'b0;
			o_bias_select         <= BIAS_RESET;
			o_frame_divider_code  <= FD_RESET;               // R2
		end else begin
			if (c_mode) begin
				o_backplane_select <= cur[MODE_BPS];
				o_inversion_mode   <= cur[MODE_INV];
				o_power_down       <= cur[MODE_PD];
				o_display_enable   <= cur[MODE_E];
			end
			if (c_osc) begin
				o_external_freq_range <= cur[OSC_EFR];
				o_clock_output_enable <= cur[OSC_COE];
				o_oscillator_source   <= cur[OSC_SRC];
			end
			if (c_bias)
				o_bias_select <= cur[1:0];
			// unused codes leave the old divider in place
			if (c_frame && fd_in)
				o_frame_divider_code <= cur[4:0];            // R1
		end
	end

	// ----------------------------------------------------------------
	// data pointer and display ram
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n || init_ok) begin
			o_data_pointer  <= DP_RESET;                     // R12
			o_pointer_valid <= 1'b1;
		end else if (c_ptr) begin
			if (ptr_in)
				o_data_pointer <= cur[5:0];                  // R4
			o_pointer_valid <= ptr_in;                       // R6
		end else if (wr_ram) begin
			o_data_pointer  <= ptr_inc;                      // R7
			o_pointer_valid <= (ptr_inc <= DP_MAX);
		end
	end

	// no reset: contents survive the reset pin
	always_ff @(posedge i_ref_clk) begin
		if (wr_ram)
			ram[o_data_pointer] <= cur;                      // R8 R15
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			o_rd_data <= 8'h00;
		else if (i_rd_addr <= DP_MAX)
			o_rd_data <= ram[i_rd_addr];
		else
			o_rd_data <= 8'h00;
	end

	assign o_outputs_grounded = !o_display_enable || o_power_down;   // R11

	// ----------------------------------------------------------------
	// prescaler and clock pin
	// ----------------------------------------------------------------
	logic       pin_s1;
	logic       pin_s2;
	logic       pin_s3;
	logic [6:0] q_cnt;
	logic [5:0] fr_cnt;
	logic       mid_clk;
	wire  [6:0] q_sel   = lcd_q(o_frame_divider_code);
	// 9.6 kHz external clock bypasses q
	wire        use_q   = !o_oscillator_source || o_external_freq_range;
	wire        src_tick = o_oscillator_source ? (pin_s2 && !pin_s3) : 1'b1;
	wire        q_tick  = src_tick && (!use_q || q_cnt == q_sel - 7'h01);
	wire        run     = !o_power_down;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			pin_s3 <= 1'b0;
		end else begin
			pin_s1 <= i_clock_pin;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n || !run) begin
			q_cnt        <= 7'h00;
			fr_cnt       <= 6'h00;
			o_frame_tick <= 1'b0;
			mid_clk      <= 1'b0;
		end else begin
			if (src_tick)
				q_cnt <= q_tick ? 7'h00 : q_cnt + 7'h01;     // R3
			if (q_tick)
				fr_cnt <= (fr_cnt == FRAME_DIV - 6'h01) ? 6'h00
				                                       : fr_cnt + 6'h01;
			o_frame_tick <= q_tick && (fr_cnt == FRAME_DIV - 6'h01);  // R3
			// duty follows q, as on silicon
			mid_clk <= (q_cnt < {1'b0, q_sel[6:1]});
		end
	end

	// pin driven only for internal clock out; the driven value is high when powered down
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_clock_pin    <= 1'b0;
			o_clock_pin_oe <= 1'b0;                          // R13
		end else begin
			o_clock_pin_oe <= o_clock_output_enable && !o_oscillator_source;
			o_clock_pin    <= o_power_down ? 1'b1 : mid_clk;
		end
	end
endmodule : lcd_dev
`default_nettype wire

// *** verilog/lcd_host.sv ***
// host end: start-up initialize, then user byte pass-through
`timescale 1ns/100ps
`default_nettype none
module lcd_host (
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst_n,
	lcd_link_if.host               link,
	input  wire logic              i_byte_valid,
	input  wire logic              i_byte_ctrl,
	input  wire lcd_pkg::lcd_byte_t i_byte,
	output logic                   o_byte_ready,
	output logic                   o_init_done,
	output logic                   o_ram_filled
);
	import lcd_pkg::*;

	typedef enum logic [1:0] {
		HS_CTRL  = 2'b00,
		HS_INIT0 = 2'b01,
		HS_INIT1 = 2'b10,
		HS_USER  = 2'b11
	} lcd_hstate_t;

	lcd_hstate_t hs;
	lcd_byte_t   seq_byte;
	logic        data_mode;

	// ----------------------------------------------------------------
	// start-up sequence, then user stream
	// ----------------------------------------------------------------
	// initialize goes out first after every reset R10 R16 R18
	always_comb begin
		seq_byte = CTRL_CMD;
		unique case (hs)
			HS_CTRL:  seq_byte = CTRL_CMD;
			HS_INIT0: seq_byte = INIT_BYTE0;
			HS_INIT1: seq_byte = INIT_BYTE1;
			HS_USER:  seq_byte = i_byte;
		endcase
	end

	assign o_init_done  = (hs == HS_USER);
	assign link.valid   = o_init_done ? i_byte_valid : 1'b1;
	assign link.ctrl    = o_init_done ? i_byte_ctrl : (hs == HS_CTRL);
	assign link.data    = seq_byte;
	assign o_byte_ready = o_init_done && link.ready;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			hs <= HS_CTRL;
		else if (!o_init_done && link.ready)
			hs <= lcd_hstate_t'(hs + 2'b01);
	end

	// tracks whether ram was written since init; advisory for display on
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			data_mode    <= 1'b0;
			o_ram_filled <= 1'b0;
		end else if (o_init_done && i_byte_valid && link.ready) begin
			if (i_byte_ctrl)
				data_mode <= (i_byte[RS_LSB+1:RS_LSB] == RS_DATA);  // R9
			else if (data_mode)
				o_ram_filled <= 1'b1;                        // R17
		end
	end
endmodule : lcd_host
`default_nettype wire

// *** tb/lcd_link_props.sv ***
// checker for the lcd link and the driver's visible state
`timescale 1ns/100ps
`default_nettype none
module lcd_link_props
	import lcd_pkg::*;
(
	input wire logic       i_ref_clk,
	input wire logic       i_rst_n,
	input wire logic       valid,
	input wire logic       ready,
	input wire logic       ctrl,
	input wire lcd_byte_t  data,
	input wire logic       o_initialized,
	input wire logic       o_display_enable,
	input wire logic       o_outputs_grounded,
	input wire logic       o_power_down,
	input wire logic [1:0] o_bias_select,
	input wire logic [4:0] o_frame_divider_code,
	input wire logic       o_clock_output_enable,
	input wire logic       o_oscillator_source,
	input wire logic       o_clock_pin_oe,
	input wire logic [5:0] o_data_pointer,
	input wire logic       o_pointer_valid,
	input wire logic       o_frame_tick
);
	logic [11:0] gap;
	logic        dirty;
	wire         off_default = o_power_down || o_oscillator_source
		|| (o_frame_divider_code != FD_RESET);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// frames touched by a code change or reset are not judged
	always_ff @(posedge i_ref_clk) begin
		gap <= (!i_rst_n || o_frame_tick) ? 12'h000 : gap + 12'h001;
		dirty <= !i_rst_n || off_default || (dirty && !o_frame_tick);
	end
	sequence init_lead;
		valid && ready && !ctrl && data == INIT_BYTE0;
	endsequence
	sequence init_tail;
		valid && ready && !ctrl && data == INIT_BYTE1;
	endsequence
	chk_fd_legal: assert property (o_frame_divider_code <= FD_LAST)
		else $error("frame divider code out of range");
	chk_frame_gap: assert property (o_frame_tick && !dirty |-> gap == 12'h47F)
		else $error("frame period wrong at default code");
	chk_start_fields: assert property ($rose(i_rst_n) |->
		o_frame_divider_code == FD_RESET && o_bias_select == BIAS_RESET
		&& o_data_pointer == DP_RESET && !o_display_enable && !o_power_down
		&& !o_oscillator_source && !o_clock_output_enable && !o_initialized)
		else $error("field not at start value after reset");
	chk_init_taken: assert property (init_lead ##1 init_tail |-> ##[1:12] o_initialized)
		else $error("initialize pair not taken");
	chk_init_clears: assert property ($rose(o_initialized) |-> o_data_pointer == DP_RESET)
		else $error("pointer not cleared by initialize");
	chk_held_off: assert property (!o_initialized |-> !o_display_enable
		&& o_frame_divider_code == FD_RESET)
		else $error("command acted on before initialize");
	chk_out_ground: assert property (!o_display_enable |-> o_outputs_grounded)
		else $error("outputs not grounded while display off");
	chk_pin_float: assert property (!o_clock_output_enable &&
		$past(o_clock_output_enable) == 1'b0 |-> !o_clock_pin_oe)
		else $error("clock pin driven without output enable");
	chk_ptr_range: assert property (o_pointer_valid |-> o_data_pointer <= DP_MAX)
		else $error("valid pointer beyond last column");
endmodule : lcd_link_props
`default_nettype wire

// *** tb/test_lcd_ram_pointer_and_startup.sv ***
// self-checking bench: host and driver joined over the byte link
`timescale 1ns/100ps
`default_nettype none
module test_lcd_ram_pointer_and_startup;
	import lcd_pkg::*;
	logic       i_ref_clk  = 1'b0;
	logic       i_rst_n    = 1'b0;
	logic       byte_valid = 1'b0;
	logic       byte_ctrl  = 1'b0;
	lcd_byte_t  byte_in    = 8'h00;
	logic [5:0] rd_addr    = 6'h00;
	logic       saw_full   = 1'b0;
	lcd_byte_t  rd_data;
	logic       byte_ready, init_done, initialized, disp_en, grounded;
	logic       pd, clock_output_enable, osc, pin_oe, ptr_valid, tick, backplane_select, inversion_mode, external_freq_range, filled;
	logic [1:0] bias;
	logic [4:0] fd;
	logic [5:0] ptr;
	int         fail_count  = 0;
	int         check_count = 0;
	always #5 i_ref_clk = ~i_ref_clk;
	lcd_link_if link();
	lcd_host lcd_host_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(link),
		.i_byte_valid(byte_valid), .i_byte_ctrl(byte_ctrl), .i_byte(byte_in),
		.o_byte_ready(byte_ready), .o_init_done(init_done),
		.o_ram_filled(filled));
	lcd_dev lcd_dev_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(link),
		.i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_initialized(initialized),
		.o_display_enable(disp_en), .o_outputs_grounded(grounded),
		.o_backplane_select(backplane_select), .o_inversion_mode(inversion_mode), .o_power_down(pd),
		.o_bias_select(bias), .o_frame_divider_code(fd),
		.o_external_freq_range(external_freq_range), .o_clock_output_enable(clock_output_enable),
		.o_oscillator_source(osc), .o_data_pointer(ptr),
		.o_pointer_valid(ptr_valid), .o_frame_tick(tick),
		.i_clock_pin(1'b0), .o_clock_pin(), .o_clock_pin_oe(pin_oe));
	lcd_link_props lcd_link_props_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.valid(link.valid), .ready(link.ready), .ctrl(link.ctrl),
		.data(link.data), .o_initialized(initialized),
		.o_display_enable(disp_en), .o_outputs_grounded(grounded),
		.o_power_down(pd), .o_bias_select(bias), .o_frame_divider_code(fd),
		.o_clock_output_enable(clock_output_enable), .o_oscillator_source(osc),
		.o_clock_pin_oe(pin_oe), .o_data_pointer(ptr),
		.o_pointer_valid(ptr_valid), .o_frame_tick(tick));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	task automatic hang();
		fail_count++;
		$display("wrong value wait expected event seen timeout");
		tally_and_finish();
	endtask : hang
	task automatic check(string name, logic [15:0] exp, logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic await(ref logic s, input int lim);
		for (int i = 0; i < lim; i++) begin
			@(posedge i_ref_clk);
			if (s === 1'b1)
				return;
		end
		hang();
	endtask : await
	// valid stays up between bytes so back-to-back bytes leave no gap
	task automatic send(input logic c, input lcd_byte_t b);
		byte_valid <= 1'b1;
		byte_ctrl <= c;
		byte_in <= b;
		for (int i = 0; i < 200; i++) begin
			@(posedge i_ref_clk);
			if (byte_ready === 1'b1)
				return;
			saw_full = 1'b1;
		end
		hang();
	endtask : send
	task automatic idle(input int n);
		byte_valid <= 1'b0;
		repeat (n) @(posedge i_ref_clk);
	endtask : idle
	task automatic peek(input logic [5:0] a, input lcd_byte_t e);
		rd_addr <= a;
		repeat (2) @(posedge i_ref_clk);
		check("ram", 16'(e), 16'(rd_data));
	endtask : peek
	task automatic do_reset();
		i_rst_n <= 1'b0;
		repeat (20) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		await(init_done, 50);
		await(initialized, 50);
	endtask : do_reset
	task automatic frame_gap(input logic [15:0] exp);
		int n;
		await(tick, 2000);
		n = 0;
		do begin
			@(posedge i_ref_clk);
			n++;
		end while (tick !== 1'b1 && n < 4000);
		check("frame gap", exp, 16'(n));
	endtask : frame_gap
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_start();
		check("code", 16'(FD_RESET), 16'(fd));
		check("pointer", 16'(DP_RESET), 16'(ptr));
		check("grounded", 16'h0001, 16'(grounded));
		check("pin oe", 16'h0000, 16'(pin_oe));
	endtask : t_start
	task automatic t_fill();
		send(1'b1, CTRL_CMD);
		send(1'b0, {OP_PTR, 6'h2A});
		send(1'b1, CTRL_DATA);
		send(1'b0, 8'hA5);
		send(1'b0, 8'h5A);
		idle(20);
		peek(6'h2A, 8'hA5);
		peek(6'h2B, 8'h5A);
		check("ptr valid", 16'h0000, 16'(ptr_valid));
		send(1'b1, CTRL_CMD);
		send(1'b0, {OP_PTR, 6'h00});
		send(1'b1, CTRL_DATA);
		saw_full = 1'b0;
		for (int i = 0; i < 40; i++)
			send(1'b0, 8'h80 + 8'(i));
		idle(40);
		check("fifo full", 16'h0001, 16'(saw_full));
		check("ram filled", 16'h0001, 16'(filled));
		check("pointer", 16'h0028, 16'(ptr));
		peek(6'h00, 8'h80);
		peek(6'h27, 8'hA7);
	endtask : t_fill
	task automatic t_bad_ptr();
		send(1'b1, CTRL_CMD);
		send(1'b0, {OP_PTR, 6'h00});
		send(1'b0, {OP_PTR, 6'h2C});
		send(1'b1, CTRL_DATA);
		send(1'b0, 8'hFF);
		send(1'b1, CTRL_CMD);
		send(1'b0, {OP_PTR, 6'h3F});
		send(1'b1, CTRL_DATA);
		send(1'b0, 8'hFE);
		idle(20);
		check("ptr valid", 16'h0000, 16'(ptr_valid));
		peek(6'h00, 8'h80);
	endtask : t_bad_ptr
	task automatic t_select();
		send(1'b1, CTRL_CMD);
		send(1'b0, {OP_PTR, 6'h05});
		send(1'b1, 8'h40);
		send(1'b0, 8'h9B);
		send(1'b1, CTRL_CMD);
		send(1'b0, {OP_PTR, 6'h06});
		idle(20);
		peek(6'h05, 8'h85);
		check("pointer", 16'h0006, 16'(ptr));
		// initialize again without reset must pull the pointer home
		send(1'b0, INIT_BYTE0);
		send(1'b0, INIT_BYTE1);
		idle(20);
		check("pointer", 16'(DP_RESET), 16'(ptr));
	endtask : t_select
	task automatic t_frame();
		frame_gap(16'h0480);
		send(1'b1, CTRL_CMD);
		send(1'b0, {OP_FRAME, 5'h16});
		idle(10);
		check("code", 16'h0016, 16'(fd));
		frame_gap(16'h0300);
		send(1'b0, {OP_FRAME, 5'h17});
		idle(10);
		check("code", 16'h0016, 16'(fd));
		send(1'b0, {OP_FRAME, 5'h08});
		send(1'b0, {OP_MODE, 4'hD});
		idle(10);
		check("grounded", 16'h0000, 16'(grounded));
		check("mode bits", 16'h0003, 16'({backplane_select, inversion_mode}));
		frame_gap(16'h0660);
		// move bias, frequency range and clock output enable off their start values so reset has work to do
		send(1'b0, {OP_BIAS, 2'h3});
		send(1'b0, {OP_OSC, 3'h6});
		idle(10);
		check("bias", 16'h0003, 16'(bias));
		check("freq range", 16'h0001, 16'(external_freq_range));
		check("pin oe", 16'h0001, 16'(pin_oe));
	endtask : t_frame
	task automatic t_reset_keep();
		do_reset();
		check("display", 16'h0000, 16'(disp_en));
		check("code", 16'(FD_RESET), 16'(fd));
		check("bias", 16'(BIAS_RESET), 16'(bias));
		check("pointer", 16'(DP_RESET), 16'(ptr));
		check("mode bits", 16'h0000, 16'({backplane_select, inversion_mode}));
		check("freq range", 16'h0000, 16'(external_freq_range));
		check("pin oe", 16'h0000, 16'(pin_oe));
		check("ram filled", 16'h0000, 16'(filled));
		peek(6'h2B, 8'h5A);
		peek(6'h00, 8'h80);
	endtask : t_reset_keep
	initial begin
		do_reset();
		t_start();
		t_fill();
		t_bad_ptr();
		t_select();
		t_frame();
		t_reset_keep();
		tally_and_finish();
	end
endmodule : test_lcd_ram_pointer_and_startup
`default_nettype wire
